// >>> hdl/channel_counter.sv
// module: one 16-bit channel counter with clear, wrap detection and byte-lane CPU load
module channel_counter
   import timer_gate_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic standby,
   count_bus_if.counter cb
);
   logic [15:0] count;
   logic wrap;

   assign cb.value = count;
   assign cb.wrap = wrap;

   // count, clear or load; CPU write wins and suppresses counting that cycle
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         count <= COUNT_RESET;
      end
      else if (cb.wrHi || cb.wrLo)
      begin
         if (cb.wrHi)
         begin
            count[15:8] <= cb.wrData[15:8];
         end
         if (cb.wrLo)
         begin
            count[7:0] <= cb.wrData[7:0];
         end
      end
      else if (cb.clear)
      begin
         count <= COUNT_RESET;
      end
      else if (cb.pulse)
      begin
         if (cb.down)
         begin
            count <= count - COUNT_ONE;
         end
         else
         begin
            count <= count + COUNT_ONE;
         end
      end
   end

   // one-cycle overflow pulse on wrap in either direction
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         wrap <= 1'b0;
      end
      else
      begin
         wrap <= !(cb.wrHi || cb.wrLo) && !cb.clear && cb.pulse &&
            ((!cb.down && count == COUNT_ALL_ONES) ||
            (cb.down && count == COUNT_RESET));
      end
   end
endmodule : channel_counter

// >>> hdl/count_bus_if.sv
// interface: strobes and data between the register front end and one channel counter
interface count_bus_if;
   logic [15:0] wrData;
   logic wrHi;
   logic wrLo;
   logic pulse;
   logic clear;
   logic down;
   logic [15:0] value;
   logic wrap;

   modport ctrl
   (
      output wrData, wrHi, wrLo, pulse, clear, down,
      input value, wrap
   );
   modport counter
   (
      input wrData, wrHi, wrLo, pulse, clear, down,
      output value, wrap
   );
endinterface : count_bus_if

// >>> hdl/timer_gate_pkg.sv
// package: offsets, field positions, reset values and mode codes of the timer gate and counters
package timer_gate_pkg;
   // channel and counter geometry
   localparam int CHANNELS = 5;
   localparam int COUNT_WIDTH = 16;
   localparam int PIN_COUNT = 6;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   // register byte offsets on the internal bus, one 16-bit slot each
   localparam logic [3:0] OFS_MASTER_ENABLE = 4'h0;
   localparam logic [3:0] OFS_OUTPUT_CONTROL = 4'h2;
   localparam logic [3:0] OFS_PIN_STATUS = 4'h4;
   localparam logic [3:0] OFS_COUNT_BASE = 4'h6;
   localparam logic [3:0] OFS_COUNT_STEP = 4'h2;

   // reset values and read-only masks of the 8-bit registers
   localparam logic [7:0] MASTER_ENABLE_RESET = 8'hFF;
   localparam logic [7:0] MASTER_ENABLE_RO_MASK = 8'hC0;
   localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'hFF;
   localparam logic [7:0] OUTPUT_CONTROL_RO_MASK = 8'hEC;
   localparam logic [7:0] TRIGGER_CLEAR_MASK = 8'h3F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // pin index equals its bit in the master enable register
   localparam int PIN_CH3_A = 0;
   localparam int PIN_CH4_A = 1;
   localparam int PIN_CH4_B = 2;
   localparam int PIN_CH3_B = 3;
   localparam int PIN_AUX_A = 4;
   localparam int PIN_AUX_B = 5;
   localparam int GROUP_A_LAST_PIN = 2;

   // output control fields
   localparam int BIT_EXT_TRIGGER_DISABLE = 4;
   localparam int BIT_LEVEL_SELECT_A = 1;
   localparam int BIT_LEVEL_SELECT_B = 0;

   // combination mode codes for channels 3 and 4
   localparam logic [1:0] COMBO_COMPLEMENTARY = 2'h2;
   localparam logic [1:0] COMBO_RESET_SYNC = 2'h3;

   // channel numbers with special counting
   localparam int CH_PHASE = 2;
   localparam int CH_PAIR_FIRST = 3;
endpackage : timer_gate_pkg

// >>> hdl/timer_output_gate_and_counters.sv
// module: output gating of channel 3/4 pins and the five channel counters with their register front end
// register map, one 16-bit slot per even byte offset:
//   0x0 master enable, low lane; bits 7:6 read one
//   0x2 output control, low lane; bits 7:5 and 3:2 read one
//   0x4 pin status, read only: {2'b0, pinOe, 2'b0, pinOut}
//   0x6, 0x8, 0xA, 0xC, 0xE counters of channels 0 to 4
// unmapped offsets ignore writes and read zero
// a lane that is not enabled reads zero
// pin index, equal to its master enable bit:
//   0 channel-3 A, 1 channel-4 A, 2 channel-4 B
//   3 channel-3 B, 4 auxiliary A, 5 auxiliary B
// pins 0 to 2 follow group A level select, pins 3 to 5 group B
// a disabled pin is released to the generic port logic with pinOe low
// counter priority each edge: CPU write, then clear, then pulse
// overflow set requests lag the wrapping pulse by two cycles
// counter direction:
//   channels 0 and 1 always count up
//   channel 2 may count down only in phase counting mode
//   channels 3 and 4 may count down only in complementary PWM mode
// a down request is ignored wherever down counting is not allowed
// combination code 2 is complementary PWM, 3 reset-synchronized PWM
// codes 0 and 1 leave channels 3 and 4 in normal operation
// level selects and trigger disable matter only in the two combined modes
// trigger: channel-1 capture A clears master enable bits 5 to 0
//   when a combined mode is on and trigger disable is low
// the trigger clear beats a same-cycle CPU write to master enable
// standby acts exactly like the synchronous reset while high
module timer_output_gate_and_counters
   import timer_gate_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic standby,
   input wire logic busSel,
   input wire logic busWrite,
   input wire logic [3:0] busAddr,
   input wire logic [1:0] busByteEn,
   input wire logic [15:0] busWdata,
   output logic [15:0] busRdata,
   output logic busAck,
   input wire logic [4:0] countPulse,
   input wire logic [4:0] countDownReq,
   input wire logic phaseMode,
   input wire logic [4:0] clearEvent,
   input wire logic ch1CaptureA,
   input wire logic [1:0] combinationMode,
   input wire logic [5:0] wavePin,
   input wire logic [5:0] waveOe,
   output logic [5:0] pinOut,
   output logic [5:0] pinOe,
   output logic [4:0] overflowSet
);
   logic [7:0] outputMasterEnable;
   logic [7:0] outputControl;
   logic comboPwm;
   logic complementary;
   logic extTrigger;
   logic wrMasterEnable;
   logic wrOutputControl;
   logic [15:0] countValue [CHANNELS];
   logic [4:0] wrapPulse;
   logic [5:0] invertPin;
   logic [5:0] gateOe;
   logic [5:0] next_pinOut;
   logic [4:0] countHit;
   logic [15:0] next_busRdata;

   // write data with read-only bits forced to one
   function automatic logic [7:0] withReserved(input logic [7:0] data, input logic [7:0] roMask);
      return data | roMask;
   endfunction : withReserved

   // byte-lane mask: an unselected lane reads zero
   function automatic logic [15:0] laneMask(input logic [1:0] be);
      logic [15:0] mask;
      mask = '0;
      if (be[1])
      begin
         mask[15:8] = 8'hFF;
      end
      if (be[0])
      begin
         mask[7:0] = 8'hFF;
      end
      return mask;
   endfunction : laneMask

   // byte offset of a channel counter slot
   function automatic logic [3:0] countAddr(input int ch);
      logic [3:0] step;
      step = OFS_COUNT_STEP * 4'(ch);
      return OFS_COUNT_BASE + step;
   endfunction : countAddr

   // true when the bus selects a write to the given offset
   function automatic logic writeHit(input logic sel, input logic wr, input logic [3:0] addr,
      input logic [3:0] ofs);
      return sel && wr && (addr == ofs);
   endfunction : writeHit

   // true for either of the two combined PWM modes
   function automatic logic isComboPwm(input logic [1:0] mode);
      return (mode == COMBO_COMPLEMENTARY) || (mode == COMBO_RESET_SYNC);
   endfunction : isComboPwm

   // mode decode of channels 3 and 4
   assign comboPwm = isComboPwm(combinationMode);
   assign complementary = (combinationMode == COMBO_COMPLEMENTARY);

   // channel-1 capture A acts as trigger only in combined modes with triggering enabled
   assign extTrigger = ch1CaptureA && comboPwm && !outputControl[BIT_EXT_TRIGGER_DISABLE];

   // the 8-bit registers sit in the low byte lane
   assign wrMasterEnable = writeHit(busSel, busWrite, busAddr, OFS_MASTER_ENABLE) && busByteEn[0];
   assign wrOutputControl = writeHit(busSel, busWrite, busAddr, OFS_OUTPUT_CONTROL) && busByteEn[0];

   // master enable register; the trigger clear beats a same-cycle CPU write for safety
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         outputMasterEnable <= MASTER_ENABLE_RESET;
      end
      else if (extTrigger)
      begin
         outputMasterEnable <= outputMasterEnable & ~TRIGGER_CLEAR_MASK;
      end
      else if (wrMasterEnable)
      begin
         outputMasterEnable <= withReserved(busWdata[7:0], MASTER_ENABLE_RO_MASK);
      end
   end

   // output control register; reserved bits always held at one
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         outputControl <= OUTPUT_CONTROL_RESET;
      end
      else if (wrOutputControl)
      begin
         outputControl <= withReserved(busWdata[7:0], OUTPUT_CONTROL_RO_MASK);
      end
   end

   // per-pin inversion, only in combined PWM modes
   generate
      for (genvar p = 0; p < PIN_COUNT; p++)
      begin : g_invert
         if (p <= GROUP_A_LAST_PIN)
         begin : g_group_a
            assign invertPin[p] = comboPwm && !outputControl[BIT_LEVEL_SELECT_A];
         end
         else
         begin : g_group_b
            assign invertPin[p] = comboPwm && !outputControl[BIT_LEVEL_SELECT_B];
         end
      end
   endgenerate

   // per-pin gating by the master enable bit of the same index
   generate
      for (genvar p = 0; p < PIN_COUNT; p++)
      begin : g_gate
         if (p == PIN_CH3_A)
         begin : g_ch3_a
            assign gateOe[p] = waveOe[p] && outputMasterEnable[p];
         end
         else if (p == PIN_CH4_A)
         begin : g_ch4_a
            assign gateOe[p] = waveOe[p] && outputMasterEnable[p];
         end
         else if (p == PIN_CH4_B)
         begin : g_ch4_b
            assign gateOe[p] = waveOe[p] && outputMasterEnable[p];
         end
         else
         begin : g_other
            assign gateOe[p] = waveOe[p] && outputMasterEnable[p];
         end
      end
   endgenerate

   // pin levels after optional inversion
   assign next_pinOut = wavePin ^ invertPin;

   // gated pin drivers; a disabled pin is left to the generic port logic
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         pinOe <= '0;
      end
      else
      begin
         pinOe <= gateOe;
      end
   end

   // pin levels after optional inversion
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         pinOut <= '0;
      end
      else
      begin
         pinOut <= next_pinOut;
      end
   end

   // the five counters, each with its own strobe bundle
   generate
      for (genvar c = 0; c < CHANNELS; c++)
      begin : g_chan
         count_bus_if cb ();
         logic downAllowed;

         // direction allowed by channel and mode
         if (c == CH_PHASE)
         begin : g_phase
            assign downAllowed = phaseMode && countDownReq[c];
         end
         else if (c >= CH_PAIR_FIRST)
         begin : g_pair
            assign downAllowed = complementary && countDownReq[c];
         end
         else
         begin : g_up
            assign downAllowed = 1'b0;
         end

         // strobes into the counter
         assign cb.wrData = busWdata;
         // slot decode of this channel's counter
         assign countHit[c] = writeHit(busSel, busWrite, busAddr, countAddr(c));
         assign cb.wrHi = countHit[c] && busByteEn[1];
         assign cb.wrLo = countHit[c] && busByteEn[0];
         assign cb.pulse = countPulse[c];
         assign cb.clear = clearEvent[c];
         assign cb.down = downAllowed;
         assign countValue[c] = cb.value;
         assign wrapPulse[c] = cb.wrap;

         channel_counter u_counter
         (
            .mclk(mclk),
            .srst(srst),
            .standby(standby),
            .cb(cb)
         );
      end
   endgenerate

   // overflow flag set requests, one cycle each
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         overflowSet <= '0;
      end
      else
      begin
         overflowSet <= wrapPulse;
      end
   end

   // read data mux; unmapped offsets read zero
   always_comb
   begin
      next_busRdata = '0;
      if (busAddr == OFS_MASTER_ENABLE)
      begin
         next_busRdata = {BYTE_ZERO, outputMasterEnable};
      end
      else if (busAddr == OFS_OUTPUT_CONTROL)
      begin
         next_busRdata = {BYTE_ZERO, outputControl};
      end
      else if (busAddr == OFS_PIN_STATUS)
      begin
         next_busRdata = {2'h0, pinOe, 2'h0, pinOut};
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (busAddr == countAddr(i))
            begin
               next_busRdata = countValue[i];
            end
         end
      end
      next_busRdata = next_busRdata & laneMask(busByteEn);
   end

   // registered read answer and acknowledge one cycle after selection
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         busRdata <= '0;
      end
      else if (busSel && !busWrite)
      begin
         busRdata <= next_busRdata;
      end
   end

   // acknowledge for reads and writes alike
   always_ff @(posedge mclk)
   begin
      if (srst || standby)
      begin
         busAck <= 1'b0;
      end
      else
      begin
         busAck <= busSel;
      end
   end
endmodule : timer_output_gate_and_counters

// >>> verification/pin_pad_model.sv
// partner model: pads of the six gated timer pins, each with a pull-up
module pin_pad_model
(
   input wire logic [5:0] pinOut,
   input wire logic [5:0] pinOe,
   output logic [5:0] padLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // a blocked pin falls back to a port pin held high by its pull-up
   assign padLevel = (pinOut & pinOe) | ~pinOe;
endmodule : pin_pad_model

// >>> verification/tb_top.sv
// testbench: registers, pin gating, trigger and counter behaviour
`define CHK(nm, e, a) \
   begin total_checks++; if ((e) !== (a)) \
   begin n_errors++; $display("Error %s expected %h seen %h", nm, (e), (a)); end end
module tb_top
   import timer_gate_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0, srst = 1'h1, standby = 1'h0, busSel = 1'h0, busWrite = 1'h0;
   logic phaseMode = 1'h0, ch1CaptureA = 1'h0, busAck;
   logic [3:0] busAddr = 4'h0;
   logic [1:0] busByteEn = 2'h0, combinationMode = 2'h0;
   logic [15:0] busWdata = 16'h0000, busRdata, rd;
   logic [4:0] countPulse = 5'h00, countDownReq = 5'h00, clearEvent = 5'h00, overflowSet;
   logic [5:0] wavePin = 6'h00, waveOe = 6'h00, pinOut, pinOe, padLevel, expOe, expOut;
   logic [7:0] me, oc;
   int n_errors = 0;
   int total_checks = 0;
   // design, pad model and clock
   timer_output_gate_and_counters dut (.*);
   pin_pad_model pads (.*);
   always #10 mclk = ~mclk;
   // inversion mask for a mode and output control value
   function automatic logic [5:0] inv_mask(input logic [1:0] cm, input logic [7:0] c);
      inv_mask = cm[1] ? {{3{~c[0]}}, {3{~c[1]}}} : 6'h00;
   endfunction : inv_mask
   // one count step as {overflow, value}
   function automatic logic [16:0] step(input int ch, input logic [15:0] v, input logic dn,
      input logic [1:0] cm, input logic ph);
      logic down;
      down = dn && ((ch == 2 && ph) || (ch >= 3 && cm == 2'h2));
      step = down ? {v == 16'h0000, v - 16'h0001} : {v == 16'hFFFF, v + 16'h0001};
   endfunction : step
   function automatic logic [3:0] cadr(input int ch);
      cadr = 4'(OFS_COUNT_BASE + ch * 2);
   endfunction : cadr
   // one bus access, optionally with count pulses in the take cycle
   task automatic acc(input logic w, input logic [3:0] a, input logic [1:0] be, input logic [15:0] d,
      input logic [4:0] pl = 5'h00);
      busSel = 1'h1;
      busWrite = w;
      busAddr = a;
      busByteEn = be;
      busWdata = d;
      countPulse = pl;
      @(negedge mclk);
      busSel = 1'h0;
      countPulse = 5'h00;
      rd = busRdata;
      `CHK("ack", 1'h1, busAck)
      @(negedge mclk);
   endtask : acc
   // load a counter, give one pulse, check overflow and value
   task automatic one_count(input int ch, input logic [15:0] v, input logic dn, input logic [1:0] cm,
      input logic ph);
      logic [16:0] e;
      e = step(ch, v, dn, cm, ph);
      combinationMode = cm;
      phaseMode = ph;
      countDownReq = {5{dn}};
      acc(1'h1, cadr(ch), 2'h3, v);
      countPulse[ch] = 1'h1;
      @(negedge mclk);
      countPulse = 5'h00;
      @(negedge mclk);
      `CHK("overflow", 5'(e[16]) << ch, overflowSet)
      acc(1'h0, cadr(ch), 2'h3, 16'h0000);
      `CHK("count", e[15:0], rd)
   endtask : one_count
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // main sequence
   initial
   begin
      void'($urandom(85));
      repeat (12) @(negedge mclk);
      srst = 1'h0;
      acc(1'h0, OFS_OUTPUT_CONTROL, 2'h1, 16'h0000);
      `CHK("control reset", 16'h00FF, rd)
      for (int ch = 0; ch < 5; ch++)
      begin
         acc(1'h0, cadr(ch), 2'h3, 16'h0000);
         `CHK("count reset", 16'h0000, rd)
      end
      // random enables, levels and modes at the pins
      for (int i = 0; i < 40; i++)
      begin
         me = (i == 0) ? 8'hFF : 8'($urandom);
         oc = 8'($urandom);
         acc(1'h0, OFS_MASTER_ENABLE, 2'h1, 16'h0000);
         `CHK("enable", 16'h00FF, rd)
         acc(1'h1, OFS_MASTER_ENABLE, 2'h1, {8'h00, me});
         acc(1'h1, OFS_OUTPUT_CONTROL, 2'h1, {8'h00, oc});
         acc(1'h0, OFS_OUTPUT_CONTROL, 2'h1, 16'h0000);
         `CHK("control", {8'h00, oc | 8'hEC}, rd)
         combinationMode = 2'($urandom);
         wavePin = 6'($urandom);
         waveOe = 6'($urandom);
         @(negedge mclk);
         expOe = waveOe & me[5:0];
         expOut = wavePin ^ inv_mask(combinationMode, oc | 8'hEC);
         `CHK("pin enable", expOe, pinOe)
         `CHK("pin level", expOut, pinOut)
         `CHK("pad", (expOut & expOe) | ~expOe, padLevel)
         me = 8'hFF;
         acc(1'h1, OFS_MASTER_ENABLE, 2'h1, 16'h00FF);
      end
      // capture trigger in every mode with trigger enabled and disabled
      for (int m = 0; m < 8; m++)
      begin
         acc(1'h1, OFS_MASTER_ENABLE, 2'h1, 16'h00FF);
         acc(1'h1, OFS_OUTPUT_CONTROL, 2'h1, {11'h000, m[2], 4'h0});
         combinationMode = 2'(m);
         ch1CaptureA = 1'h1;
         @(negedge mclk);
         ch1CaptureA = 1'h0;
         acc(1'h0, OFS_MASTER_ENABLE, 2'h1, 16'h0000);
         `CHK("trigger", (m[1] && !m[2]) ? 16'h00C0 : 16'h00FF, rd)
      end
      // wrap corners, then random starts, modes and directions
      one_count(0, 16'hFFFF, 1'h1, 2'h2, 1'h1);
      one_count(2, 16'h0000, 1'h1, 2'h0, 1'h1);
      one_count(3, 16'h0000, 1'h1, 2'h2, 1'h0);
      one_count(4, 16'h0000, 1'h1, 2'h3, 1'h0);
      for (int i = 0; i < 40; i++)
         one_count($urandom_range(0, 4), (i % 3 == 0) ? {16{i[2]}} : 16'($urandom), 1'($urandom),
            2'($urandom), 1'($urandom));
      // clear beats a pulse, a write beats a pulse, the high byte lane loads alone
      for (int ch = 0; ch < 5; ch++)
      begin
         acc(1'h1, cadr(ch), 2'h3, 16'h00AA);
         clearEvent[ch] = 1'h1;
         countPulse[ch] = 1'h1;
         @(negedge mclk);
         clearEvent = 5'h00;
         countPulse = 5'h00;
         acc(1'h0, cadr(ch), 2'h3, 16'h0000);
         `CHK("clear", 16'h0000, rd)
         acc(1'h1, cadr(ch), 2'h3, 16'hFFFF, 5'h01 << ch);
         `CHK("no wrap", 5'h00, overflowSet)
         acc(1'h1, cadr(ch), 2'h2, 16'hAB00);
         acc(1'h0, cadr(ch), 2'h3, 16'h0000);
         `CHK("byte write", 16'hABFF, rd)
      end
      // standby acts like a reset
      acc(1'h1, OFS_MASTER_ENABLE, 2'h1, 16'h0000);
      standby = 1'h1;
      @(negedge mclk);
      standby = 1'h0;
      acc(1'h0, OFS_MASTER_ENABLE, 2'h1, 16'h0000);
      `CHK("standby enable", 16'h00FF, rd)
      acc(1'h0, cadr(4), 2'h3, 16'h0000);
      `CHK("standby count", 16'h0000, rd)
      conclude();
   end
   // watchdog well beyond the sequence length
   initial
   begin
      #(20 * 5000);
      n_errors++;
      conclude();
   end
endmodule : tb_top

// >>> verification/timer_gate_chk.sv
// checker: bus, pin gating and overflow relations at the block's ports
module timer_gate_chk
   import timer_gate_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic standby,
   input wire logic busSel,
   input wire logic busWrite,
   input wire logic [3:0] busAddr,
   input wire logic [1:0] busByteEn,
   input wire logic [15:0] busRdata,
   input wire logic busAck,
   input wire logic [4:0] countPulse,
   input wire logic [1:0] combinationMode,
   input wire logic [5:0] wavePin,
   input wire logic [5:0] waveOe,
   input wire logic [5:0] pinOut,
   input wire logic [5:0] pinOe,
   input wire logic [4:0] overflowSet
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (srst || standby);
   // bus answer timing and read data lanes
   AST_ACK: assert property (busSel |=> busAck) else $error("ack missing");
   AST_NO_ACK: assert property (!busSel |=> !busAck) else $error("stray ack");
   AST_RD_HOLD: assert property (!(busSel && !busWrite) |=> $stable(busRdata)) else $error("rdata moved");
   AST_HI_LANE: assert property (busSel && !busWrite && !busByteEn[1] |=> busRdata[15:8] == 8'h00)
      else $error("high lane not zero");
   AST_LO_LANE: assert property (busSel && !busWrite && !busByteEn[0] |=> busRdata[7:0] == 8'h00)
      else $error("low lane not zero");
   AST_ME_RSVD: assert property (busSel && !busWrite && busAddr == OFS_MASTER_ENABLE && busByteEn[0]
      |=> busRdata[7:6] == 2'h3) else $error("enable reserved bits");
   AST_OC_RSVD: assert property (busSel && !busWrite && busAddr == OFS_OUTPUT_CONTROL && busByteEn[0]
      |=> (busRdata[7:0] & 8'hEC) == 8'hEC) else $error("control reserved bits");
   // pin gating and level selection
   AST_OE_GATED: assert property ((pinOe & ~$past(waveOe)) == 6'h00) else $error("pin driven unasked");
   AST_NORMAL: assert property (!combinationMode[1] |=> pinOut == $past(wavePin))
      else $error("level changed in normal mode");
   // every overflow report needs a count pulse two cycles before
   AST_OVF_CAUSE: assert property ((overflowSet & ~$past(countPulse, 2)) == 5'h00)
      else $error("overflow without pulse");
endmodule : timer_gate_chk

bind timer_output_gate_and_counters timer_gate_chk chk (.*);
